/* File: synth_cal_registers.sv */
// Synthesizer calibration and RC oscillator configuration register bank
`timescale 1ns/1ps
`include "synth_cal_defs.svh"

module synth_cal_registers (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wr_data,
   output logic [7:0] reg_rd_data,
   input wire logic cal_done,
   input wire logic [3:0] cal_result_hi_in,
   input wire logic [5:0] cal_result_mid_in,
   input wire logic [5:0] cal_result_lo_in,
   output logic [1:0] cal_config,
   output logic [1:0] charge_pump_cal_enable,
   output logic chp_cal_skip,
   output logic [3:0] result_hi,
   output logic [5:0] result_mid,
   output logic [5:0] result_lo,
   output logic [6:0] cal_control,
   output logic [6:0] rc_osc_hi,
   output logic [6:0] rc_osc_lo
);

   // -------------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------------
   synth_cal_pkg::reg_sel_t sel;

   always_comb begin
      case (reg_addr)
         `OFS_CFG_RESULT_HI: sel = synth_cal_pkg::sel_cfg_result_hi;
         `OFS_RESULT_MID: sel = synth_cal_pkg::sel_result_mid;
         `OFS_RESULT_LO: sel = synth_cal_pkg::sel_result_lo;
         `OFS_CAL_CONTROL: sel = synth_cal_pkg::sel_cal_control;
         `OFS_RC_OSC_HI: sel = synth_cal_pkg::sel_rc_osc_hi;
         `OFS_RC_OSC_LO: sel = synth_cal_pkg::sel_rc_osc_lo;
         default: sel = synth_cal_pkg::sel_none;
      endcase
   end

   logic we_cfg_hi;
   logic we_mid;
   logic we_lo;
   logic we_ctrl;
   logic we_rc_hi;
   logic we_rc_lo;

   assign we_cfg_hi = reg_wr_en && (sel == synth_cal_pkg::sel_cfg_result_hi);
   assign we_mid = reg_wr_en && (sel == synth_cal_pkg::sel_result_mid);
   assign we_lo = reg_wr_en && (sel == synth_cal_pkg::sel_result_lo);
   assign we_ctrl = reg_wr_en && (sel == synth_cal_pkg::sel_cal_control);
   assign we_rc_hi = reg_wr_en && (sel == synth_cal_pkg::sel_rc_osc_hi);
   assign we_rc_lo = reg_wr_en && (sel == synth_cal_pkg::sel_rc_osc_lo);

   // -------------------------------------------------------------------------
   // First calibration register: configuration, charge pump enable, result
   // -------------------------------------------------------------------------
   cal_reg_field #(.width(2), .rst_val(`RST_CAL_CONFIG)) u_cal_config (
      .clk(clk),
      .rst(rst),
      .host_we(we_cfg_hi),
      .host_d(reg_wr_data[`CAL_CONFIG_MSB:`CAL_CONFIG_LSB]),
      .hw_we(1'b0),
      .hw_d(2'h0),
      .q(cal_config)
   );

   cal_reg_field #(.width(2), .rst_val(`RST_CHP_EN)) u_chp_en (
      .clk(clk),
      .rst(rst),
      .host_we(we_cfg_hi),
      .host_d(reg_wr_data[`CHP_EN_MSB:`CHP_EN_LSB]),
      .hw_we(1'b0),
      .hw_d(2'h0),
      .q(charge_pump_cal_enable)
   );

   // Host write and calibration deposit share one path, so restored
   // values drive the synthesizer exactly as calibrated ones do
   cal_reg_field #(.width(4), .rst_val(`RST_RESULT_HI)) u_result_hi (
      .clk(clk),
      .rst(rst),
      .host_we(we_cfg_hi),
      .host_d(reg_wr_data[`RESULT_HI_MSB:`RESULT_HI_LSB]),
      .hw_we(cal_done),
      .hw_d(cal_result_hi_in),
      .q(result_hi)
   );

   // -------------------------------------------------------------------------
   // Second and third calibration result registers
   // -------------------------------------------------------------------------
   cal_reg_field #(.width(6), .rst_val(`RST_RESULT_MID)) u_result_mid (
      .clk(clk),
      .rst(rst),
      .host_we(we_mid),
      .host_d(reg_wr_data[`RESULT_6_MSB:`RESULT_6_LSB]),
      .hw_we(cal_done),
      .hw_d(cal_result_mid_in),
      .q(result_mid)
   );

   cal_reg_field #(.width(6), .rst_val(`RST_RESULT_LO)) u_result_lo (
      .clk(clk),
      .rst(rst),
      .host_we(we_lo),
      .host_d(reg_wr_data[`RESULT_6_MSB:`RESULT_6_LSB]),
      .hw_we(cal_done),
      .hw_d(cal_result_lo_in),
      .q(result_lo)
   );

   // -------------------------------------------------------------------------
   // Calibration control and RC oscillator configuration
   // -------------------------------------------------------------------------
   cal_reg_field #(.width(7), .rst_val(`RST_CAL_CONTROL)) u_cal_control (
      .clk(clk),
      .rst(rst),
      .host_we(we_ctrl),
      .host_d(reg_wr_data[`FIELD_7_MSB:`FIELD_7_LSB]),
      .hw_we(1'b0),
      .hw_d(7'h00),
      .q(cal_control)
   );

   cal_reg_field #(.width(7), .rst_val(`RST_RC_OSC_HI)) u_rc_osc_hi (
      .clk(clk),
      .rst(rst),
      .host_we(we_rc_hi),
      .host_d(reg_wr_data[`FIELD_7_MSB:`FIELD_7_LSB]),
      .hw_we(1'b0),
      .hw_d(7'h00),
      .q(rc_osc_hi)
   );

   cal_reg_field #(.width(7), .rst_val(`RST_RC_OSC_LO)) u_rc_osc_lo (
      .clk(clk),
      .rst(rst),
      .host_we(we_rc_lo),
      .host_d(reg_wr_data[`FIELD_7_MSB:`FIELD_7_LSB]),
      .hw_we(1'b0),
      .hw_d(7'h00),
      .q(rc_osc_lo)
   );

   // -------------------------------------------------------------------------
   // Charge pump stage skip, one cycle behind the enable field
   // -------------------------------------------------------------------------
   logic chp_skip_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         chp_skip_ff <= 1'b0;
      end else begin
         chp_skip_ff <= (charge_pump_cal_enable == 2'h0);
      end
   end

   assign chp_cal_skip = chp_skip_ff;

   // -------------------------------------------------------------------------
   // Read data, registered; reserved bits forced to zero
   // -------------------------------------------------------------------------
   synth_cal_pkg::reg_byte_t nxt_rd_data;
   synth_cal_pkg::reg_byte_t rd_data_ff;

   always_comb begin
      case (sel)
         synth_cal_pkg::sel_cfg_result_hi: nxt_rd_data = {cal_config,
                                                          charge_pump_cal_enable,
                                                          result_hi};
         synth_cal_pkg::sel_result_mid: nxt_rd_data = {2'h0, result_mid};
         synth_cal_pkg::sel_result_lo: nxt_rd_data = {2'h0, result_lo};
         synth_cal_pkg::sel_cal_control: nxt_rd_data = {1'b0, cal_control};
         synth_cal_pkg::sel_rc_osc_hi: nxt_rd_data = {1'b0, rc_osc_hi};
         synth_cal_pkg::sel_rc_osc_lo: nxt_rd_data = {1'b0, rc_osc_lo};
         default: nxt_rd_data = `RD_UNMAPPED;
      endcase
   end

   // Holds the last read value until the next read
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data_ff <= 8'h00;
      end else if (reg_rd_en) begin
         rd_data_ff <= nxt_rd_data;
      end
   end

   assign reg_rd_data = rd_data_ff;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   cfg_write_a: assert property (
      @(posedge clk) disable iff (rst)
      we_cfg_hi |=> cal_config == $past(reg_wr_data[7:6]))
      else $error("calibration configuration did not take the written value");

   chp_skip_a: assert property (
      @(posedge clk) disable iff (rst)
      (we_cfg_hi && reg_wr_data[5:4] == 2'h0) |=> ##1 chp_cal_skip)
      else $error("charge pump stage not skipped after enable written zero");

   cal_deposit_a: assert property (
      @(posedge clk) disable iff (rst)
      cal_done |=> (result_hi == $past(cal_result_hi_in))
                   && (result_mid == $past(cal_result_mid_in))
                   && (result_lo == $past(cal_result_lo_in)))
      else $error("calibration results not deposited");

   hop_restore_a: assert property (
      @(posedge clk) disable iff (rst)
      (we_lo && !cal_done) |=> result_lo == $past(reg_wr_data[5:0]))
      else $error("restored result value not applied");

   result_hold_a: assert property (
      @(posedge clk) disable iff (rst)
      (!cal_done && !we_mid) |=> $stable(result_mid))
      else $error("result value changed without write or calibration");

   ctrl_reset_a: assert property (
      @(posedge clk)
      rst |=> cal_control == 7'h0d)
      else $error("calibration control reset value wrong");

   ctrl_write_a: assert property (
      @(posedge clk) disable iff (rst)
      we_ctrl |=> cal_control == $past(reg_wr_data[6:0]))
      else $error("calibration control write lost");

   reserved_zero_a: assert property (
      @(posedge clk) disable iff (rst)
      (reg_rd_en && reg_addr == `OFS_RESULT_MID) |=> reg_rd_data[7:6] == 2'h0)
      else $error("reserved bits did not read zero");

   read_back_a: assert property (
      @(posedge clk) disable iff (rst)
      (reg_rd_en && reg_addr == `OFS_CFG_RESULT_HI)
      |=> reg_rd_data == {$past(cal_config), $past(charge_pump_cal_enable),
                          $past(result_hi)})
      else $error("first calibration register read back wrong");

endmodule : synth_cal_registers

/* File: synth_cal_defs.svh */
// Offsets, field positions and reset values of the calibration register bank
`ifndef SYNTH_CAL_DEFS_SVH
`define SYNTH_CAL_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_CFG_RESULT_HI 6'h23
`define OFS_RESULT_MID 6'h24
`define OFS_RESULT_LO 6'h25
`define OFS_CAL_CONTROL 6'h26
`define OFS_RC_OSC_HI 6'h27
`define OFS_RC_OSC_LO 6'h28

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CAL_CONFIG_MSB 7
`define CAL_CONFIG_LSB 6
`define CHP_EN_MSB 5
`define CHP_EN_LSB 4
`define RESULT_HI_MSB 3
`define RESULT_HI_LSB 0
`define RESULT_6_MSB 5
`define RESULT_6_LSB 0
`define FIELD_7_MSB 6
`define FIELD_7_LSB 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_CAL_CONFIG 2'h2
`define RST_CHP_EN 2'h2
`define RST_RESULT_HI 4'h9
`define RST_RESULT_MID 6'h0a
`define RST_RESULT_LO 6'h20
`define RST_CAL_CONTROL 7'h0d
`define RST_RC_OSC_HI 7'h41
`define RST_RC_OSC_LO 7'h00
`define RD_UNMAPPED 8'h00

`endif

/* File: synth_cal_pkg.sv */
// Types shared by the calibration register bank
package synth_cal_pkg;

   typedef logic [7:0] reg_byte_t;

   typedef enum {
      sel_none,
      sel_cfg_result_hi,
      sel_result_mid,
      sel_result_lo,
      sel_cal_control,
      sel_rc_osc_hi,
      sel_rc_osc_lo
   } reg_sel_t;

endpackage : synth_cal_pkg

/* File: cal_reg_field.sv */
// One register field with host write and hardware deposit
`timescale 1ns/1ps

module cal_reg_field #(
   parameter int width = 8,
   parameter logic [width-1:0] rst_val = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic host_we,
   input wire logic [width-1:0] host_d,
   input wire logic hw_we,
   input wire logic [width-1:0] hw_d,
   output logic [width-1:0] q
);

   logic [width-1:0] value_ff;

   // Hardware deposit wins over a host write in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         value_ff <= rst_val;
      end else if (hw_we) begin
         value_ff <= hw_d;
      end else if (host_we) begin
         value_ff <= host_d;
      end
   end

   assign q = value_ff;

endmodule : cal_reg_field

/* File: tb_synth_cal_registers.sv */
// Self-checking testbench for the calibration register bank
`timescale 1ns/1ps

module tb_synth_cal_registers;
   logic clk, rst, reg_wr_en, reg_rd_en, cal_done, chp_cal_skip;
   logic [5:0] reg_addr;
   logic [7:0] reg_wr_data, reg_rd_data;
   logic [3:0] cal_result_hi_in, result_hi;
   logic [5:0] cal_result_mid_in, cal_result_lo_in, result_mid, result_lo;
   logic [1:0] cal_config, charge_pump_cal_enable;
   logic [6:0] cal_control, rc_osc_hi, rc_osc_lo;
   int fail_count = 0;
   int cmp_count = 0;
   int m[6];
   int mask[6] = '{8'hff, 8'h3f, 8'h3f, 8'h7f, 8'h7f, 8'h7f};
   int saved[$];
   int a, d;

   synth_cal_registers uut (.clk(clk), .rst(rst), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
      .reg_rd_data(reg_rd_data), .cal_done(cal_done), .cal_result_hi_in(cal_result_hi_in),
      .cal_result_mid_in(cal_result_mid_in), .cal_result_lo_in(cal_result_lo_in),
      .cal_config(cal_config), .charge_pump_cal_enable(charge_pump_cal_enable),
      .chp_cal_skip(chp_cal_skip), .result_hi(result_hi), .result_mid(result_mid),
      .result_lo(result_lo), .cal_control(cal_control), .rc_osc_hi(rc_osc_hi),
      .rc_osc_lo(rc_osc_lo));

   // ---------------------------------------------------------------
   // Clock and watchdog
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      #200000;
      fail_count++;
      stop_test();
   end

   // ---------------------------------------------------------------
   // Compare and bus tasks
   // ---------------------------------------------------------------
   task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: read %h expected %h", $time, got, exp);
      end
   endtask : cmp_rd

   task automatic cmp_fld(input logic [41:0] got, input logic [41:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: fields %h expected %h", $time, got, exp);
      end
   endtask : cmp_fld

   task automatic wr(input int ad, input int dt);
      @(negedge clk);
      reg_wr_en = 1'b1;
      reg_addr = 6'(ad);
      reg_wr_data = 8'(dt);
      @(negedge clk);
      reg_wr_en = 1'b0;
      if (ad >= 8'h23 && ad <= 8'h28) m[ad - 8'h23] = dt & mask[ad - 8'h23];
   endtask : wr

   task automatic rd(input int ad);
      logic [7:0] exp;
      exp = (ad >= 8'h23 && ad <= 8'h28) ? 8'(m[ad - 8'h23]) : 8'h00;
      @(negedge clk);
      reg_rd_en = 1'b1;
      reg_addr = 6'(ad);
      @(negedge clk);
      reg_rd_en = 1'b0;
      cmp_rd(reg_rd_data, exp);
   endtask : rd

   // Waits one extra cycle so the registered skip flag has settled
   task automatic chk_fields();
      logic sk;
      @(negedge clk);
      sk = (m[0][5:4] == 2'h0);
      cmp_fld({cal_config, charge_pump_cal_enable, result_hi, result_mid, result_lo,
         cal_control, rc_osc_hi, rc_osc_lo, chp_cal_skip}, {8'(m[0]), 6'(m[1]), 6'(m[2]),
         7'(m[3]), 7'(m[4]), 7'(m[5]), sk});
   endtask : chk_fields

   task automatic cal(input int h, input int md, input int l);
      @(negedge clk);
      cal_done = 1'b1;
      cal_result_hi_in = 4'(h);
      cal_result_mid_in = 6'(md);
      cal_result_lo_in = 6'(l);
      @(negedge clk);
      cal_done = 1'b0;
      m[0] = (m[0] & 8'hf0) | (h & 8'h0f);
      m[1] = md & 8'h3f;
      m[2] = l & 8'h3f;
   endtask : cal

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(24));
      rst = 1'b1;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 6'h00;
      reg_wr_data = 8'h00;
      cal_done = 1'b0;
      cal_result_hi_in = 4'h0;
      cal_result_mid_in = 6'h00;
      cal_result_lo_in = 6'h00;
      m = '{8'ha9, 8'h0a, 8'h20, 8'h0d, 8'h41, 8'h00};
      repeat (4) @(negedge clk);
      rst = 1'b0;
      // Reset values, unmapped neighbours included
      for (a = 8'h22; a <= 8'h29; a++) rd(a);
      chk_fields();
      // Random host writes with read-back
      repeat (24) begin
         a = 8'h23 + $urandom_range(0, 3);
         wr(a, $urandom);
         rd(a);
      end
      wr(8'h2a, 8'hff);
      rd(8'h2a);
      chk_fields();
      // Charge pump enable codes
      for (d = 0; d < 4; d++) begin
         wr(8'h23, 8'h85 | (d << 4));
         chk_fields();
      end
      // Calibrate per frequency and save results
      repeat (3) begin
         cal($urandom, $urandom, $urandom);
         chk_fields();
         for (a = 8'h23; a <= 8'h25; a++) begin
            rd(a);
            saved.push_back(m[a - 8'h23]);
         end
      end
      // Hop by restoring saved results in reverse order
      cal($urandom, $urandom, $urandom);
      while (saved.size() > 0) begin
         for (a = 8'h25; a >= 8'h23; a--) wr(a, saved.pop_back());
         chk_fields();
      end
      // Deposit and host write on one edge
      @(negedge clk);
      cal_done = 1'b1;
      cal_result_hi_in = 4'h6;
      cal_result_mid_in = 6'h15;
      cal_result_lo_in = 6'h33;
      reg_wr_en = 1'b1;
      reg_rd_en = 1'b1;
      reg_addr = 6'h24;
      reg_wr_data = 8'h2a;
      @(negedge clk);
      cal_done = 1'b0;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      cmp_rd(reg_rd_data, 8'(m[1]));
      m[0] = (m[0] & 8'hf0) | 8'h06;
      m[1] = 8'h15;
      m[2] = 8'h33;
      rd(8'h24);
      chk_fields();
      stop_test();
   end
endmodule : tb_synth_cal_registers
